// ---- verilog/i2crs_slave.sv ----
// Serial bus register access slave with byte index auto-increment
//
// Function
// - Write select: next byte is index
// - Store data at index, then increment
// - Nonexistent register: NACK, index unchanged
// - Index past 255 wraps to 0
// - ACK select, index and accepted data
// - Bare read select uses retained index
// - Read burst returns consecutive registers
// - Address fixed upper bits, select pin
// - Index increments as each byte is loaded for sending
`timescale 1ns/1ps
`default_nettype none
module i2crs_slave #(
   parameter logic [255:0] REG_PRESENT = i2crs_pkg::I2CRS_PRESENT_DEF
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic scl_clk,
   input wire logic sda_in,
   output var logic sda_out,
   output var logic sda_oe,
   input wire logic adr_sel,
   output var logic wr_valid,
   output var i2crs_pkg::i2crs_wr_t wr,
   output var logic [7:0] rd_index,
   input wire logic [7:0] rd_data
);
   import i2crs_pkg::*;

   // -------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------
   logic [1:0] pin_s;
   logic [1:0] pin_prev_q, pin_prev_d;
   logic frame_q, frame_d;
   logic st_tgl_q, st_tgl_d;
   logic [2:0] lk_s;
   logic [1:0] lk_prev_q, lk_prev_d;
   logic fetch_pend_q, fetch_pend_d;
   logic [7:0] rd_byte_q, rd_byte_d;
   logic [7:0] rd_index_d;
   logic wr_valid_d;
   i2crs_wr_t wr_d;
   logic sda_oe_d;
   logic start_det, stop_det;

   logic scl_rst;
   logic st_s;
   logic adr_s;
   logic rx_bit_q;
   logic rx_prev_q;
   i2crs_phase_t phase_q, phase_d;
   logic [3:0] cnt_q, cnt_d;
   logic [7:0] sh_q, sh_d;
   logic [7:0] idx_q, idx_d;
   logic [7:0] tx_q, tx_d;
   logic drv_q, drv_d;
   logic st_seen_q, st_seen_d;
   i2crs_wr_t wr_hold_q, wr_hold_d;
   logic wr_tgl_q, wr_tgl_d;
   logic fetch_tgl_q, fetch_tgl_d;
   logic [7:0] byte_w;

   // -------------------------------------------------------------
   // System domain: pin watch, crossings, user ports
   // -------------------------------------------------------------
   i2crs_sync #(.W(2)) u_sync_pin (
      .clk(sys_clk),
      .rst(srst),
      .d({scl_clk, sda_in}),
      .q(pin_s)
   );

   i2crs_sync #(.W(3)) u_sync_link (
      .clk(sys_clk),
      .rst(srst),
      .d({drv_q, wr_tgl_q, fetch_tgl_q}),
      .q(lk_s)
   );

   assign start_det = pin_prev_q[1] & pin_s[1] & pin_prev_q[0] & ~pin_s[0];
   assign stop_det = pin_prev_q[1] & pin_s[1] & ~pin_prev_q[0] & pin_s[0];

   always_comb begin
      pin_prev_d = pin_s;
      lk_prev_d = lk_s[1:0];
      st_tgl_d = st_tgl_q ^ start_det;
      frame_d = frame_q;
      if (start_det) begin
         frame_d = 1'b1;
      end else if (stop_det) begin
         frame_d = 1'b0;
      end
      // Drive only inside a frame; stale link state is masked
      sda_oe_d = lk_s[2] & frame_q;
      wr_valid_d = 1'b0;
      wr_d = wr;
      // Hold words are stable for many link cycles after a toggle
      if (lk_s[1] != lk_prev_q[1]) begin
         wr_valid_d = 1'b1;
         wr_d = wr_hold_q;
      end
      rd_index_d = rd_index;
      rd_byte_d = rd_byte_q;
      fetch_pend_d = 1'b0;
      if (lk_s[0] != lk_prev_q[0]) begin
         rd_index_d = idx_q;
         fetch_pend_d = 1'b1;
      end else if (fetch_pend_q) begin
         rd_byte_d = rd_data;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         pin_prev_q <= 2'h3;
         lk_prev_q <= 2'h0;
         st_tgl_q <= 1'b0;
         frame_q <= 1'b0;
         sda_oe <= 1'b0;
         sda_out <= 1'b0;
         wr_valid <= 1'b0;
         wr <= '0;
         rd_index <= I2CRS_IDX_RST;
         rd_byte_q <= I2CRS_BYTE_RST;
         // Prefetch the reset index so a bare read is correct
         fetch_pend_q <= 1'b1;
      end else begin
         pin_prev_q <= pin_prev_d;
         lk_prev_q <= lk_prev_d;
         st_tgl_q <= st_tgl_d;
         frame_q <= frame_d;
         sda_oe <= sda_oe_d;
         sda_out <= 1'b0;
         wr_valid <= wr_valid_d;
         wr <= wr_d;
         rd_index <= rd_index_d;
         rd_byte_q <= rd_byte_d;
         fetch_pend_q <= fetch_pend_d;
      end
   end

   // -------------------------------------------------------------
   // Link domain: bit capture and byte engine on the serial clock
   // -------------------------------------------------------------
   i2crs_sync #(.W(1)) u_sync_rst (
      .clk(~scl_clk),
      .rst(1'b0),
      .d(srst),
      .q(scl_rst)
   );

   i2crs_sync #(.W(2)) u_sync_st (
      .clk(~scl_clk),
      .rst(scl_rst),
      .d({st_tgl_q, adr_sel}),
      .q({st_s, adr_s})
   );

   always_ff @(posedge scl_clk) begin
      rx_bit_q <= sda_in;
      rx_prev_q <= rx_bit_q;
   end

   assign byte_w = {sh_q[6:0], rx_bit_q};

   always_comb begin
      phase_d = phase_q;
      cnt_d = cnt_q;
      sh_d = sh_q;
      idx_d = idx_q;
      tx_d = tx_q;
      drv_d = drv_q;
      st_seen_d = st_seen_q;
      wr_hold_d = wr_hold_q;
      wr_tgl_d = wr_tgl_q;
      fetch_tgl_d = fetch_tgl_q;
      if (st_s != st_seen_q) begin
         // Sync costs two falls; first two bits taken from history
         st_seen_d = st_s;
         phase_d = I2CRS_ADDR;
         cnt_d = I2CRS_CNT_FIRST;
         sh_d = {6'h00, rx_prev_q, rx_bit_q};
         drv_d = 1'b0;
      end else if (phase_q == I2CRS_IDLE) begin
         drv_d = 1'b0;
      end else if (cnt_q == I2CRS_CNT_ACK) begin
         cnt_d = I2CRS_CNT_RST;
         drv_d = 1'b0;
         // Master NACK ends the read burst
         if (phase_q == I2CRS_RFIRST ||
             (phase_q == I2CRS_RDATA && !rx_bit_q)) begin
            tx_d = {rd_byte_q[6:0], 1'b0};
            drv_d = ~rd_byte_q[7];
            phase_d = I2CRS_RDATA;
            idx_d = idx_q + 8'h01;
            fetch_tgl_d = ~fetch_tgl_q;
         end else if (phase_q == I2CRS_RDATA) begin
            phase_d = I2CRS_IDLE;
         end
      end else begin
         cnt_d = cnt_q + 4'h1;
         sh_d = byte_w;
         if (phase_q == I2CRS_RDATA) begin
            drv_d = (cnt_q == I2CRS_CNT_LAST) ? 1'b0 : ~tx_q[7];
            tx_d = {tx_q[6:0], 1'b0};
         end else if (cnt_q == I2CRS_CNT_LAST) begin
            case (phase_q)
               I2CRS_ADDR: begin
                  if (byte_w[7:1] == {I2CRS_ADDR_HI, adr_s}) begin
                     drv_d = 1'b1;
                     phase_d = byte_w[0] ? I2CRS_RFIRST : I2CRS_INDEX;
                  end else begin
                     phase_d = I2CRS_IDLE;
                  end
               end
               I2CRS_INDEX: begin
                  if (REG_PRESENT[byte_w]) begin
                     drv_d = 1'b1;
                     idx_d = byte_w;
                     fetch_tgl_d = ~fetch_tgl_q;
                     phase_d = I2CRS_WDATA;
                  end else begin
                     phase_d = I2CRS_IDLE;
                  end
               end
               I2CRS_WDATA: begin
                  // No store or increment if missing
                  if (REG_PRESENT[idx_q]) begin
                     drv_d = 1'b1;
                     wr_hold_d = '{index: idx_q, data: byte_w};
                     wr_tgl_d = ~wr_tgl_q;
                     // Eight-bit add wraps 255 to 0
                     idx_d = idx_q + 8'h01;
                     fetch_tgl_d = ~fetch_tgl_q;
                  end
               end
               default: begin
                  drv_d = 1'b0;
               end
            endcase
         end
      end
   end

   // Link state survives STOP; only reset clears the index
   always_ff @(negedge scl_clk) begin
      if (scl_rst) begin
         phase_q <= I2CRS_IDLE;
         cnt_q <= I2CRS_CNT_RST;
         sh_q <= I2CRS_BYTE_RST;
         idx_q <= I2CRS_IDX_RST;
         tx_q <= I2CRS_BYTE_RST;
         drv_q <= 1'b0;
         st_seen_q <= 1'b0;
         wr_hold_q <= '0;
         wr_tgl_q <= 1'b0;
         fetch_tgl_q <= 1'b0;
      end else begin
         phase_q <= phase_d;
         cnt_q <= cnt_d;
         sh_q <= sh_d;
         idx_q <= idx_d;
         tx_q <= tx_d;
         drv_q <= drv_d;
         st_seen_q <= st_seen_d;
         wr_hold_q <= wr_hold_d;
         wr_tgl_q <= wr_tgl_d;
         fetch_tgl_q <= fetch_tgl_d;
      end
   end
endmodule
`default_nettype wire

// ---- verilog/i2crs_pkg.sv ----
// Constants and types for the serial register access slave
`default_nettype none
package i2crs_pkg;
   // -------------------------------------------------------------
   // Bus address and framing
   // -------------------------------------------------------------
   localparam logic [5:0] I2CRS_ADDR_HI = 6'h16;
   localparam logic [3:0] I2CRS_CNT_LAST = 4'h7;
   localparam logic [3:0] I2CRS_CNT_ACK = 4'h8;
   // Bits already held when the link logic notices a START
   localparam logic [3:0] I2CRS_CNT_FIRST = 4'h2;
   localparam logic [3:0] I2CRS_CNT_RST = 4'h0;
   localparam int I2CRS_SYNC_STAGES = 2;
   // -------------------------------------------------------------
   // Reset values and default register map
   // -------------------------------------------------------------
   localparam logic [7:0] I2CRS_IDX_RST = 8'h00;
   localparam logic [7:0] I2CRS_BYTE_RST = 8'h00;
   localparam logic [255:0] I2CRS_PRESENT_DEF = 256'hffff_ffff;

   typedef enum logic [2:0] {
      I2CRS_IDLE,
      I2CRS_ADDR,
      I2CRS_INDEX,
      I2CRS_WDATA,
      I2CRS_RFIRST,
      I2CRS_RDATA
   } i2crs_phase_t;

   typedef struct packed {
      logic [7:0] index;
      logic [7:0] data;
   } i2crs_wr_t;
endpackage
`default_nettype wire

// ---- verilog/i2crs_sync.sv ----
// Two-stage level synchroniser with synchronous reset
`timescale 1ns/1ps
`default_nettype none
module i2crs_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output var logic [W-1:0] q
);
   import i2crs_pkg::*;

   logic [W-1:0] meta_q;

   // First stage feeds only the second stage
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule
`default_nettype wire

// ---- tb/i2crs_checker.sv ----
// Port assertions for the serial register access slave
`timescale 1ns/1ps
`default_nettype none
module i2crs_checker #(
   parameter logic [255:0] REG_PRESENT = i2crs_pkg::I2CRS_PRESENT_DEF
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic scl_clk,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic adr_sel,
   input wire logic wr_valid,
   input wire i2crs_pkg::i2crs_wr_t wr,
   input wire logic [7:0] rd_index,
   input wire logic [7:0] rd_data
);
   import i2crs_pkg::*;
   // ---------------------------------------------
   // Sequences and properties
   // ---------------------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (srst);
   sequence s_ack_soon;
      ##[0:4] sda_oe;
   endsequence
   sequence s_idx_next;
      ##[0:4] rd_index == wr.index + 8'h01;
   endsequence
   a_sda_open_drain: assert property (sda_out == 1'b0)
      else $error("data output not held low");
   a_reset_quiet: assert property ($fell(srst) |->
      !sda_oe && !wr_valid && rd_index == 8'h00)
      else $error("outputs not idle after reset");
   a_wr_one_pulse: assert property (wr_valid |=> !wr_valid)
      else $error("write strobe longer than one cycle");
   a_wr_index_step: assert property (wr_valid |-> s_idx_next)
      else $error("index not advanced after write");
   a_wr_present: assert property (wr_valid |-> REG_PRESENT[wr.index])
      else $error("write to absent register");
   a_wr_acked: assert property (wr_valid |-> s_ack_soon)
      else $error("accepted byte not acknowledged");
   a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_clk)
      else $error("data wire moved while clock high");
   a_oe_stands: assert property ($rose(sda_oe) |=> sda_oe [*8])
      else $error("acknowledge released too early");
   a_wr_hold: assert property ($changed(wr) |-> wr_valid)
      else $error("write word changed without strobe");
endmodule
bind i2crs_slave i2crs_checker #(.REG_PRESENT(REG_PRESENT)) i2crs_checker_i (
   .sys_clk(sys_clk), .srst(srst), .scl_clk(scl_clk), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe(sda_oe), .adr_sel(adr_sel),
   .wr_valid(wr_valid), .wr(wr), .rd_index(rd_index), .rd_data(rd_data)
);
`default_nettype wire

// ---- tb/i2crs_master.sv ----
// Bus master model driving the serial clock and data wire
`timescale 1ns/1ps
`default_nettype none
module i2crs_master (
   output var logic scl,
   output var logic sda_low,
   input wire logic sda
);
   // ---------------------------------------------
   // Bit timing, 1 us period; slave lags too much for 32 ns
   // ---------------------------------------------
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // Fast pulses with the data wire idle, to clear link state
   task automatic warm();
      repeat (3) begin
         scl = 1'b0;
         #16;
         scl = 1'b1;
         #16;
      end
   endtask
   task automatic bitx(input logic d, output logic r);
      sda_low = !d;
      #250;
      scl = 1'b1;
      #500;
      r = sda;
      scl = 1'b0;
      #250;
   endtask
   task automatic start();
      sda_low = 1'b0;
      #250;
      scl = 1'b1;
      #500;
      sda_low = 1'b1;
      #500;
      scl = 1'b0;
      #250;
   endtask
   task automatic stop();
      sda_low = 1'b1;
      #250;
      scl = 1'b1;
      #500;
      sda_low = 1'b0;
      #500;
   endtask
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bitx(d[i], r);
      bitx(1'b1, r);
      ack = !r;
   endtask
   task automatic rbyte(input logic more, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
      bitx(!more, r);
   endtask
endmodule
`default_nettype wire

// ---- tb/i2crs_slave_tb.sv ----
// Self-checking bench for the register access slave
`timescale 1ns/1ps
`default_nettype none
module i2crs_slave_tb;
   import i2crs_pkg::*;
   // One absent register at 0x40 to exercise refusals
   localparam logic [255:0] PRES = ~(256'h1 << 64);
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   logic adr_sel = 1'b1;
   logic scl, sda_low, sda_in, sda_out, sda_oe, wr_valid, a;
   logic [7:0] rd_index, rd_data, b;
   logic [7:0] mem [256];
   i2crs_wr_t wr;
   int miscompares = 0;
   int n_tests = 0;
   // Pull-up on the shared data wire
   assign sda_in = !(sda_low || sda_oe === 1'b1);
   assign rd_data = mem[rd_index];
   always #5 sys_clk = !sys_clk;
   always @(posedge sys_clk) begin
      if (wr_valid) begin
         mem[wr.index] <= wr.data;
      end
   end
   initial begin
      for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
   end
   i2crs_slave #(.REG_PRESENT(PRES)) i2crs_slave_i (
      .sys_clk(sys_clk), .srst(srst), .scl_clk(scl), .sda_in(sda_in),
      .sda_out(sda_out), .sda_oe(sda_oe), .adr_sel(adr_sel),
      .wr_valid(wr_valid), .wr(wr), .rd_index(rd_index), .rd_data(rd_data)
   );
   i2crs_master i2crs_master_i (.scl(scl), .sda_low(sda_low), .sda(sda_in));
   // ---------------------------------------------
   // Helpers
   // ---------------------------------------------
   task automatic chk(string n, logic [7:0] g, logic [7:0] x);
      n_tests++;
      if (g !== x) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", n, x, g);
      end
   endtask
   task automatic sel(logic [7:0] s, logic x);
      i2crs_master_i.start();
      i2crs_master_i.wbyte(s, a);
      chk("select ack", 8'(a), 8'(x));
   endtask
   task automatic wb(logic [7:0] d, logic x);
      i2crs_master_i.wbyte(d, a);
      chk("byte ack", 8'(a), 8'(x));
   endtask
   task automatic rb(logic more, logic [7:0] x);
      i2crs_master_i.rbyte(more, b);
      chk("read data", b, x);
   endtask
   task automatic summarize();
      $display("tests %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic t_bad_addr();
      sel(8'h58, 1'b0);
      i2crs_master_i.stop();
      @(posedge sys_clk);
      #1;
      adr_sel = 1'b0;
      sel(8'h58, 1'b1);
      i2crs_master_i.stop();
      sel(8'h5a, 1'b0);
      i2crs_master_i.stop();
      @(posedge sys_clk);
      #1;
      adr_sel = 1'b1;
   endtask
   task automatic t_wr_wrap();
      sel(8'h5a, 1'b1);
      wb(8'hfe, 1'b1);
      wb(8'h11, 1'b1);
      wb(8'h22, 1'b1);
      wb(8'h33, 1'b1);
      i2crs_master_i.stop();
      chk("reg fe", mem[8'hfe], 8'h11);
      chk("reg 00", mem[8'h00], 8'h33);
      sel(8'h5b, 1'b1);
      rb(1'b0, 8'h5b);
      i2crs_master_i.stop();
   endtask
   task automatic t_rand_read();
      sel(8'h5a, 1'b1);
      wb(8'hfe, 1'b1);
      sel(8'h5b, 1'b1);
      rb(1'b1, 8'h11);
      rb(1'b1, 8'h22);
      rb(1'b0, 8'h33);
      i2crs_master_i.stop();
   endtask
   task automatic t_absent();
      sel(8'h5a, 1'b1);
      wb(8'h40, 1'b0);
      i2crs_master_i.stop();
      sel(8'h5b, 1'b1);
      rb(1'b0, 8'h5b);
      i2crs_master_i.stop();
      sel(8'h5a, 1'b1);
      wb(8'h3f, 1'b1);
      wb(8'h77, 1'b1);
      wb(8'h88, 1'b0);
      i2crs_master_i.stop();
      chk("reg 40", mem[8'h40], 8'h1a);
      sel(8'h5a, 1'b1);
      wb(8'h3f, 1'b1);
      sel(8'h5b, 1'b1);
      rb(1'b0, 8'h77);
      i2crs_master_i.stop();
   endtask
   initial begin
      fork
         i2crs_master_i.warm();
         repeat (10) @(posedge sys_clk);
      join
      #1;
      srst = 1'b0;
      repeat (5) @(posedge sys_clk);
      // Link logic leaves reset only on serial clock falls
      i2crs_master_i.warm();
      t_bad_addr();
      t_wr_wrap();
      t_rand_read();
      t_absent();
      summarize();
   end
   initial begin
      repeat (90000) @(posedge sys_clk);
      miscompares++;
      summarize();
   end
endmodule
`default_nettype wire
